//--- tei_pkg.sv
// Purpose: shared constants for the timer/event counter and its interrupt
// Assumes: 8-bit register data in the low bits of a 32-bit apb word
// Notes:   byte addresses are word aligned
package tei_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_CNT_LO  = 8'h04;
  localparam logic [7:0] ADDR_CNT_HI  = 8'h08;
  localparam logic [7:0] ADDR_INTC    = 8'h0c;
  localparam logic [7:0] ADDR_PORTDIR = 8'h10;

  // control register field positions
  localparam int CTRL_EDGE_BIT  = 3;
  localparam int CTRL_RUN_BIT   = 4;
  localparam int CTRL_MODE_LO   = 6;
  localparam int CTRL_MODE_HI   = 7;

  // interrupt control field positions
  localparam int INTC_GIE_BIT   = 0;
  localparam int INTC_IEN_BIT   = 2;
  localparam int INTC_FLAG_BIT  = 5;

  // port direction bit of the shared timer input pin
  localparam int PORTDIR_TMR_BIT = 2;

  // values after reset
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  PORTDIR_RESET = 8'hff;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;

  // counter limits and interrupt vector
  localparam logic [15:0] COUNT_MAX     = 16'hffff;
  localparam logic [11:0] TIMER_VECTOR  = 12'h008;

  // mode field codes {high, low}
  localparam logic [1:0] MODE_TIMER = 2'b10;
  localparam logic [1:0] MODE_EVENT = 2'b01;
  localparam logic [1:0] MODE_PULSE = 2'b11;

endpackage

//--- tei_irq_if.sv
// Purpose: carrier between the counter core and the interrupt unit
// Assumes: single clock domain
// Notes:   sw_wr is a one-cycle strobe with sw_wdata valid
interface tei_irq_if;
  logic       ovf;
  logic       sw_wr;
  logic [7:0] sw_wdata;
  logic       gie;
  logic       ien;
  logic       flag;

  modport core (output ovf, output sw_wr, output sw_wdata,
                input gie, input ien, input flag);
  modport irq  (input ovf, input sw_wr, input sw_wdata,
                output gie, output ien, output flag);
endinterface

//--- tei_sync.sv
// Purpose: two-stage synchroniser and edge detector for the timer pin
// Assumes: pin is fully asynchronous to clk_in
// Notes:   edges are flagged in the same cycle that the second stage updates
module tei_sync (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } tei_sync_t;

  tei_sync_t s_q;
  tei_sync_t s_d;

  // meta is read only by sync, never by edge logic
  always_comb
  begin
    s_d      = s_q;
    s_d.meta = pin_in;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  // reset to the pull-high idle level, so leaving reset makes no false edge
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      s_q <= '1;
    else
      s_q <= s_d;
  end

  assign level_out = s_q.sync;
  assign rise_out  = s_q.sync & ~s_q.prev;
  assign fall_out  = ~s_q.sync & s_q.prev;

endmodule // tei_sync

//--- tei_irq.sv
// Purpose: request flag, enables and vector call for the counter interrupt
// Assumes: cpu performs the push, pop and vector load on our strobes
// Notes:   the cpu owns the stack; only the program counter is saved
module tei_irq (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  tei_irq_if.irq    bus,
  input  wire logic instr_boundary_in,
  input  wire logic stack_full_in,
  input  wire logic power_down_in,
  input  wire logic reti_in,
  output logic      call_out,
  output logic      pc_pop_out,
  output logic      in_service_out
);

  typedef struct packed {
    logic gie;
    logic ien;
    logic flag;
    logic in_service;
  } tei_irq_t;

  tei_irq_t s_q;
  tei_irq_t s_d;
  logic     accept;

  // take the vector only at a boundary, never while asleep or stack full
  assign accept = instr_boundary_in & s_q.gie & s_q.ien & s_q.flag
                & ~stack_full_in
                & ~power_down_in;

  always_comb
  begin
    s_d = s_q;
    if (bus.sw_wr)
    begin
      s_d.gie  = bus.sw_wdata[tei_pkg::INTC_GIE_BIT];
      s_d.ien  = bus.sw_wdata[tei_pkg::INTC_IEN_BIT];
      s_d.flag = bus.sw_wdata[tei_pkg::INTC_FLAG_BIT];
    end
    // service clears flag and global enable; no nesting unless sw re-enables
    if (accept)
    begin
      s_d.flag       = 1'b0;
      s_d.gie        = 1'b0;
      s_d.in_service = 1'b1;
    end
    // overflow is latched even while blocked; set beats any clear
    if (bus.ovf)
      s_d.flag = 1'b1;
    if (reti_in)
      s_d.in_service = 1'b0;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign call_out       = accept;
  assign pc_pop_out     = reti_in & s_q.in_service;
  assign in_service_out = s_q.in_service;
  assign bus.gie        = s_q.gie;
  assign bus.ien        = s_q.ien;
  assign bus.flag       = s_q.flag;

endmodule // tei_irq

//--- tei_timer.sv
// Purpose: 16-bit timer/event counter with apb registers and interrupt
// Assumes: pclk is clk_in; the cpu pushes pc and loads the vector on call
// Notes:   counter may lose up to two ticks while software touches the count
//
// Function
// - pull-high option stays active in timer use
// - timer mode counts every system clock
// - pulse mode counts while input condition holds
// - event input synchronised before counting
// - counting inhibited during count read or preload
// - control bit four starts and stops counting
// - overflow sets the counter request flag
// - overflow never wakes from power down
// - interrupt needs global, timer enable and flag
// - global enable low blocks all service
// - service pushes pc, jumps to 08h
// - service clears flag and global enable
// - requests during service stay latched
// - full stack holds off interrupt acknowledge
// - flag stays set until serviced or cleared
// - return pops pc and resumes
// - only pc saved on interrupt entry
// - mode decode: timer 10, event 01, pulse 11
// - overflow reloads preload and keeps counting
// - pulse end clears run bit automatically
// - low byte buffered until high byte write
//
// Decided for this implementation: the placing of the registers and the APB register port.
module tei_timer (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // shared pin
  input  wire logic        shared_timer_input_pin_in,
  input  wire logic        pull_high_option_in,
  output logic             pin_pull_high_out,
  output logic      [7:0]  port_a_direction_out,
  output logic             timer_input_selected_out,
  // cpu sequencing
  input  wire logic        instr_boundary_in,
  input  wire logic        stack_full_in,
  input  wire logic        power_down_in,
  input  wire logic        reti_in,
  output logic             irq_call_out,
  output logic      [11:0] irq_vector_out,
  output logic             pc_pop_out,
  output logic             in_service_out
);

  typedef struct packed {
    logic [7:0]  ctrl;        // mode, edge select, run bit
    logic [7:0]  port_dir;    // port a direction, 1 = input
    logic [15:0] count;
    logic [15:0] preload;
    logic [7:0]  lo_wbuf;     // low byte held until high byte write
    logic [7:0]  lo_rbuf;     // low byte latched by high byte read
    logic        pw_active;   // pulse measurement in progress
    logic [31:0] rdata;
    logic        slverr;
    logic        ovf;
  } tei_state_t;

  tei_state_t s_q;
  tei_state_t s_d;

  tei_irq_if  ibus ();

  logic       pin_level;
  logic       pin_rise;
  logic       pin_fall;
  logic       setup;
  logic       access;
  logic       wr_acc;
  logic       rd_acc;
  logic       mapped;
  logic       cnt_touch;
  logic [1:0] mode;
  logic       edge_sel;
  logic       run;
  logic       start_edge;
  logic       end_edge;
  logic       tick;
  logic [7:0] wbyte;
  logic [7:0] intc_view;

  // external input never reaches the counter unsynchronised
  tei_sync u_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .pin_in    (shared_timer_input_pin_in),
    .level_out (pin_level),
    .rise_out  (pin_rise),
    .fall_out  (pin_fall)
  );

  tei_irq u_irq (
    .clk_in            (clk_in),
    .resetn_in         (resetn_in),
    .bus               (ibus),
    .instr_boundary_in (instr_boundary_in),
    .stack_full_in     (stack_full_in),
    .power_down_in     (power_down_in),
    .reti_in           (reti_in),
    .call_out          (irq_call_out),
    .pc_pop_out        (pc_pop_out),
    .in_service_out    (in_service_out)
  );

  // apb phase decode; slave never waits
  assign setup  = psel_in & ~penable_in;
  assign access = psel_in & penable_in;
  assign wr_acc = access & pwrite_in & pstrb_in[0];
  assign rd_acc = access & ~pwrite_in;
  assign wbyte  = pwdata_in[7:0];

  assign mapped = (paddr_in == tei_pkg::ADDR_CTRL)
                | (paddr_in == tei_pkg::ADDR_CNT_LO)
                | (paddr_in == tei_pkg::ADDR_CNT_HI)
                | (paddr_in == tei_pkg::ADDR_INTC)
                | (paddr_in == tei_pkg::ADDR_PORTDIR);

  // any apb cycle aimed at the count bytes freezes counting
  // setup and access both hold the clock off, so a running timer loses
  // up to two ticks per count access; software must allow for that
  assign cnt_touch = psel_in & ((paddr_in == tei_pkg::ADDR_CNT_HI)
                   | (paddr_in == tei_pkg::ADDR_CNT_LO));

  // control field views
  assign mode     = {s_q.ctrl[tei_pkg::CTRL_MODE_HI],
                     s_q.ctrl[tei_pkg::CTRL_MODE_LO]};
  assign edge_sel = s_q.ctrl[tei_pkg::CTRL_EDGE_BIT];
  assign run      = s_q.ctrl[tei_pkg::CTRL_RUN_BIT];

  // edge select low: pulse is low-going, event counts rising edges
  assign start_edge = edge_sel ? pin_rise : pin_fall;
  assign end_edge   = edge_sel ? pin_fall : pin_rise;

  // count enable per mode
  // pin edges come through the synchroniser, so a count lags the pin by
  // about three clocks; pulses shorter than a clock may be missed
  // in pulse mode the arming cycle is not counted either
  always_comb
  begin
    tick = 1'b0;
    if (run && !cnt_touch)
    begin
      unique case (mode)
        tei_pkg::MODE_TIMER: tick = 1'b1;
        tei_pkg::MODE_EVENT: tick = edge_sel ? pin_fall : pin_rise;
        tei_pkg::MODE_PULSE: tick = s_q.pw_active & ~end_edge;
        default:             tick = 1'b0;
      endcase
    end
  end

  // interrupt control read view
  always_comb
  begin
    intc_view = 8'h00;
    intc_view[tei_pkg::INTC_GIE_BIT]  = ibus.gie;
    intc_view[tei_pkg::INTC_IEN_BIT]  = ibus.ien;
    intc_view[tei_pkg::INTC_FLAG_BIT] = ibus.flag;
  end

  // overflow is a one-cycle pulse; the request flag lives in the irq unit
  assign ibus.ovf      = s_q.ovf;
  assign ibus.sw_wr    = wr_acc & (paddr_in == tei_pkg::ADDR_INTC);
  assign ibus.sw_wdata = wbyte;

  // next state
  always_comb
  begin
    s_d     = s_q;
    s_d.ovf = 1'b0;

    // counting; overflow reloads and keeps going
    if (tick)
    begin
      if (s_q.count == tei_pkg::COUNT_MAX)
      begin
        s_d.count = s_q.preload;
        s_d.ovf   = 1'b1;
      end
      else
        s_d.count = s_q.count + 16'h0001;
    end

    // pulse width sequencing: one shot, then run drops
    if (mode == tei_pkg::MODE_PULSE && run)
    begin
      if (!s_q.pw_active && start_edge)
        s_d.pw_active = 1'b1;
      else if (s_q.pw_active && end_edge)
      begin
        s_d.pw_active                    = 1'b0;
        s_d.ctrl[tei_pkg::CTRL_RUN_BIT]  = 1'b0;
      end
    end
    else
      s_d.pw_active = 1'b0; // later edges ignored until run set again

    // register writes, taken in the access phase
    if (wr_acc)
    begin
      unique case (paddr_in)
        tei_pkg::ADDR_CTRL:
        begin
          // sw write wins over a same-cycle auto clear of run
          s_d.ctrl      = wbyte;
          s_d.pw_active = 1'b0;
        end
        tei_pkg::ADDR_CNT_LO: s_d.lo_wbuf = wbyte;
        tei_pkg::ADDR_CNT_HI:
        begin
          s_d.preload = {wbyte, s_q.lo_wbuf};
          // stopped timer takes the preload at once
          if (!run)
            s_d.count = {wbyte, s_q.lo_wbuf};
        end
        tei_pkg::ADDR_PORTDIR: s_d.port_dir = wbyte;
        default: ;
      endcase
    end

    // high byte read latches the live low byte for a later low read
    if (rd_acc && paddr_in == tei_pkg::ADDR_CNT_HI)
      s_d.lo_rbuf = s_q.count[7:0];

    // read data prepared in the setup phase, so prdata is a flop
    if (setup)
    begin
      s_d.rdata  = 32'h0000_0000;
      s_d.slverr = ~mapped;
      unique case (paddr_in)
        tei_pkg::ADDR_CTRL:    s_d.rdata[7:0] = s_q.ctrl;
        tei_pkg::ADDR_CNT_LO:  s_d.rdata[7:0] = s_q.lo_rbuf;
        tei_pkg::ADDR_CNT_HI:  s_d.rdata[7:0] = s_q.count[15:8];
        tei_pkg::ADDR_INTC:    s_d.rdata[7:0] = intc_view;
        tei_pkg::ADDR_PORTDIR: s_d.rdata[7:0] = s_q.port_dir;
        default:               s_d.rdata      = 32'h0000_0000;
      endcase
    end
  end

  // state register; count has a defined reset value although sw must load it
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_q          <= '0;
      s_q.ctrl     <= tei_pkg::CTRL_RESET;
      s_q.port_dir <= tei_pkg::PORTDIR_RESET;
      s_q.count    <= tei_pkg::COUNT_RESET;
      s_q.preload  <= tei_pkg::COUNT_RESET;
    end
    else
      s_q <= s_d;
  end

  // apb answers: zero wait states
  // unmapped addresses read as zero with an error; writes there are dropped
  assign pready_out  = 1'b1;
  assign prdata_out  = s_q.rdata;
  assign pslverr_out = access & s_q.slverr;

  // pin routing; pull-high option is never overridden by timer use
  // the counter owns the pin only as an input in an external mode
  assign pin_pull_high_out        = pull_high_option_in;
  assign port_a_direction_out     = s_q.port_dir;
  assign timer_input_selected_out = s_q.port_dir[tei_pkg::PORTDIR_TMR_BIT]
                                  & (mode == tei_pkg::MODE_EVENT
                                  |  mode == tei_pkg::MODE_PULSE);

  // vector only; accumulator and status are left to software
  assign irq_vector_out = tei_pkg::TIMER_VECTOR;

endmodule // tei_timer

//--- tei_timer_sva.sv
// Purpose: port checks for the counter interrupt path
// Assumes: one clock, reset low active and asynchronous
// Notes:   sees only ports of tei_timer
module tei_timer_sva (
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic        pull_high_option_in,
  input wire logic        pin_pull_high_out,
  input wire logic        instr_boundary_in,
  input wire logic        stack_full_in,
  input wire logic        power_down_in,
  input wire logic        reti_in,
  input wire logic        irq_call_out,
  input wire logic [11:0] irq_vector_out,
  input wire logic        pc_pop_out,
  input wire logic        in_service_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  // call gating, entry and return of the interrupt service
  property p_call_gate;
    irq_call_out |-> instr_boundary_in && !stack_full_in && !power_down_in;
  endproperty
  a_call_gate: assert property (p_call_gate)
    else $error("call taken while blocked");
  property p_vector;
    irq_call_out |-> irq_vector_out == tei_pkg::TIMER_VECTOR;
  endproperty
  a_vector: assert property (p_vector)
    else $error("wrong vector on call");
  property p_no_nest; irq_call_out |=> !irq_call_out; endproperty
  a_no_nest: assert property (p_no_nest)
    else $error("second call without global enable");
  property p_enter; irq_call_out |=> in_service_out; endproperty
  a_enter: assert property (p_enter)
    else $error("service not entered after call");
  property p_rise; $rose(in_service_out) |-> $past(irq_call_out); endproperty
  a_rise: assert property (p_rise)
    else $error("service entered without call");
  property p_pop; reti_in && in_service_out |-> pc_pop_out; endproperty
  a_pop: assert property (p_pop)
    else $error("return did not pop");
  property p_leave;
    pc_pop_out && !irq_call_out |=> !in_service_out;
  endproperty
  a_leave: assert property (p_leave)
    else $error("service not left after return");
  property p_pull; pin_pull_high_out == pull_high_option_in; endproperty
  a_pull: assert property (p_pull)
    else $error("pull-high option lost");
endmodule // tei_timer_sva

bind tei_timer tei_timer_sva u_sva (.clk_in, .resetn_in,
  .pull_high_option_in, .pin_pull_high_out, .instr_boundary_in,
  .stack_full_in, .power_down_in, .reti_in, .irq_call_out,
  .irq_vector_out, .pc_pop_out, .in_service_out);

//--- tei_pin_src.sv
// Purpose: external event source on the shared timer pin
// Assumes: the pin has its pull-high option, so idle is high
// Notes:   edges land off the clock grid on purpose
module tei_pin_src (
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // rest at the pull-high level between pulses
  initial pin_out = 1'b1;
  // low-going pulses, timing unrelated to the clock
  task automatic pulses(input int n, input int lo_ns, input int hi_ns);
    // step off the clock edge so the first change never races a sample
    #7;
    repeat (n)
    begin
      pin_out = 1'b0;
      #(lo_ns);
      pin_out = 1'b1;
      #(hi_ns);
    end
  endtask
endmodule // tei_pin_src

//--- tei_tb.sv
// Purpose: directed checks of the timer/event counter over apb
// Assumes: 20 mhz clock; tei_pin_src drives the shared pin
// Notes:   pulse width allows one tick of synchroniser jitter
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 1'b0, resetn_in = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, dir, c;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, pin, selp, call, pop, insvc, e;
  logic        bnd = 1'b0, sf = 1'b0, pd = 1'b0, reti = 1'b0;
  logic [11:0] vec;
  int          n_fail = 0, check_count = 0, n_call = 0;

  tei_timer dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .shared_timer_input_pin_in(pin), .pull_high_option_in(1'b1),
    .pin_pull_high_out(), .port_a_direction_out(dir),
    .timer_input_selected_out(selp), .instr_boundary_in(bnd),
    .stack_full_in(sf), .power_down_in(pd), .reti_in(reti),
    .irq_call_out(call), .irq_vector_out(vec), .pc_pop_out(pop),
    .in_service_out(insvc));
  tei_pin_src src (.pin_out(pin));

  // free-running clock
  initial forever #25 clk_in = ~clk_in;
  // calls counted mid-cycle, where the comb strobe has settled
  always @(negedge clk_in) if (call === 1'b1) n_call++;

  // one apb transfer; held until pready is seen at an edge
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [7:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(a, 1'b0, 8'h00);
  endtask
  task automatic chk(input string nm, input logic [31:0] x, got);
    check_count++;
    if (got !== x)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, x, got);
    end
  endtask
  task automatic final_report;
    if (n_fail == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watchdog: the sequence needs about 15 us
  initial
  begin
    #100us;
    n_fail++;
    final_report;
  end

  // main sequence
  initial
  begin
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(tei_pkg::ADDR_CTRL);
    chk("ctrl reset", 32'h00, r);
    rd(tei_pkg::ADDR_PORTDIR);
    chk("dir reset", 32'hff, r);
    rd(8'h14);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    // low byte buffered until the high byte, read via high latch
    wr(tei_pkg::ADDR_CNT_LO, 8'h9b);
    wr(tei_pkg::ADDR_CNT_HI, 8'haa);
    rd(tei_pkg::ADDR_CNT_HI);
    chk("count hi", 32'haa, r);
    rd(tei_pkg::ADDR_CNT_LO);
    chk("count lo", 32'h9b, r);
    // timer mode from just below overflow; reload keeps high ff
    wr(tei_pkg::ADDR_CNT_LO, 8'hf0);
    wr(tei_pkg::ADDR_CNT_HI, 8'hff);
    wr(tei_pkg::ADDR_CTRL, 8'h80);
    wr(tei_pkg::ADDR_CTRL, 8'h90);
    repeat (20) @(posedge clk_in);
    wr(tei_pkg::ADDR_CTRL, 8'h80);
    rd(tei_pkg::ADDR_CNT_HI);
    chk("reload hi", 32'hff, r);
    rd(tei_pkg::ADDR_INTC);
    chk("ovf flag", 32'h20, r);
    wr(tei_pkg::ADDR_INTC, 8'h00);
    // event mode, both edge selects: five synced edges each
    for (int te = 0; te < 2; te++)
    begin
      c = te ? 8'h48 : 8'h40;
      wr(tei_pkg::ADDR_CNT_LO, 8'h00);
      wr(tei_pkg::ADDR_CNT_HI, 8'h00);
      wr(tei_pkg::ADDR_CTRL, c);
      wr(tei_pkg::ADDR_CTRL, c | 8'h10);
      chk("pin selected", 32'h1, {31'h0, selp});
      src.pulses(5, 173, 211);
      repeat (6) @(posedge clk_in);
      wr(tei_pkg::ADDR_CTRL, c);
      rd(tei_pkg::ADDR_CNT_HI);
      rd(tei_pkg::ADDR_CNT_LO);
      chk("event count", 32'h05, r);
    end
    // pulse mode: a 500 ns low pulse is ten clocks
    wr(tei_pkg::ADDR_CNT_LO, 8'h00);
    wr(tei_pkg::ADDR_CNT_HI, 8'h00);
    wr(tei_pkg::ADDR_CTRL, 8'hc0);
    wr(tei_pkg::ADDR_CTRL, 8'hd0);
    src.pulses(1, 500, 300);
    repeat (4) @(posedge clk_in);
    rd(tei_pkg::ADDR_CTRL);
    chk("run cleared", 32'hc0, r);
    rd(tei_pkg::ADDR_CNT_HI);
    chk("width hi", 32'h00, r);
    rd(tei_pkg::ADDR_CNT_LO);
    chk("width lo in 9..11", 32'h1, 32'(r inside {[9:11]}));
    // pin given back to the port as an output
    wr(tei_pkg::ADDR_PORTDIR, 8'hfb);
    @(negedge clk_in);
    chk("pin released", 32'h0, {31'h0, selp});
    chk("dir out", 32'hfb, {24'h0, dir});
    rd(tei_pkg::ADDR_PORTDIR);
    chk("dir readback", 32'hfb, r);
    // interrupt blocked by each missing condition other than boundary and flag
    wr(tei_pkg::ADDR_INTC, 8'h24);
    bnd <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("no call, global off", 32'h0, n_call);
    sf <= 1'b1;
    wr(tei_pkg::ADDR_INTC, 8'h25);
    repeat (4) @(posedge clk_in);
    chk("no call, stack full", 32'h0, n_call);
    sf <= 1'b0;
    pd <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("no call, power down", 32'h0, n_call);
    // timer enable drops before power down ends, so no call slips in
    wr(tei_pkg::ADDR_INTC, 8'h21);
    pd <= 1'b0;
    rd(tei_pkg::ADDR_INTC);
    chk("flag kept", 32'h21, r);
    chk("no call, timer off", 32'h0, n_call);
    // one boundary with every condition met
    bnd <= 1'b0;
    wr(tei_pkg::ADDR_INTC, 8'h25);
    bnd <= 1'b1;
    @(posedge clk_in);
    bnd <= 1'b0;
    @(negedge clk_in);
    chk("one call", 32'h1, n_call);
    chk("in service", 32'h1, {31'h0, insvc});
    chk("vector", {20'h0, tei_pkg::TIMER_VECTOR}, {20'h0, vec});
    rd(tei_pkg::ADDR_INTC);
    chk("entry clears", 32'h04, r);
    // request during service stays latched, global still off
    bnd <= 1'b1;
    wr(tei_pkg::ADDR_INTC, 8'h24);
    rd(tei_pkg::ADDR_INTC);
    chk("latched in service", 32'h24, r);
    chk("no nested call", 32'h1, n_call);
    reti <= 1'b1;
    @(negedge clk_in);
    chk("pop on return", 32'h1, {31'h0, pop});
    @(posedge clk_in);
    reti <= 1'b0;
    bnd <= 1'b0;
    @(negedge clk_in);
    chk("service left", 32'h0, {31'h0, insvc});
    final_report;
  end
endmodule // tb
